// file: rtl/sbs_pkg.sv
// constants, instruction codes and state types for the sram boundary-scan port
package sbs_pkg;

    // scan register lengths
    localparam int BSR_LEN_X36 = 73;
    localparam int BSR_LEN_X18 = 54;
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;

    // instruction codes
    localparam logic [2:0] INSTR_EXTEST_LITE = 3'h0;
    localparam logic [2:0] INSTR_IDCODE = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_FLOAT = 3'h2;
    localparam logic [2:0] INSTR_SAMPLE = 3'h4;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;

    // capture pattern and reset values
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    localparam logic [2:0] IR_RESET = INSTR_IDCODE;
    localparam logic BYPASS_RESET = 1'h0;

    // identification word fields, msb first
    localparam logic [2:0] ID_REVISION = 3'h0;
    localparam logic [4:0] ID_DEPTH = 5'h0b;
    localparam logic [5:0] ID_ARCH = 6'h00;
    localparam logic [5:0] ID_WIDTH_X36 = 6'h24;
    localparam logic [5:0] ID_WIDTH_X18 = 6'h14;
    // arbitrary value, not a real maker code
    localparam logic [10:0] ID_VENDOR = 11'h2a5;
    localparam logic ID_PRESENT = 1'h1;

    // consecutive tms-high edges that always reach test-logic-reset
    localparam int TMS_RESET_EDGES = 5;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } sbs_tap_state_e;

    typedef enum logic [1:0] {
        PATH_BYPASS, PATH_ID, PATH_BOUNDARY
    } sbs_dr_path_e;

endpackage

// file: rtl/sbs_tap_fsm.sv
// sixteen-state test access port controller
`timescale 1ns/100ps
module sbs_tap_fsm (
    // test clock and its reset
    input wire logic testClk,
    input wire logic tckRst_n,
    // mode select pin
    input wire logic tmsPin,
    // controller state
    output sbs_pkg::sbs_tap_state_e tapState
);
    import sbs_pkg::*;

    sbs_tap_state_e state_q, state_d;

    // tms steers every transition on the rising test-clock edge
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            TAP_RESET: state_d = tmsPin ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_d = tmsPin ? SEL_DR : TAP_IDLE;
            SEL_DR: state_d = tmsPin ? SEL_IR : CAP_DR;
            CAP_DR: state_d = tmsPin ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: state_d = tmsPin ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: state_d = tmsPin ? UPD_DR : PAUSE_DR;
            PAUSE_DR: state_d = tmsPin ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: state_d = tmsPin ? UPD_DR : SHIFT_DR;
            UPD_DR: state_d = tmsPin ? SEL_DR : TAP_IDLE;
            SEL_IR: state_d = tmsPin ? TAP_RESET : CAP_IR;
            CAP_IR: state_d = tmsPin ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: state_d = tmsPin ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: state_d = tmsPin ? UPD_IR : PAUSE_IR;
            PAUSE_IR: state_d = tmsPin ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: state_d = tmsPin ? UPD_IR : SHIFT_IR;
            UPD_IR: state_d = tmsPin ? SEL_DR : TAP_IDLE;
            default: state_d = TAP_RESET;
        endcase
    end

    // five consecutive tms-high edges land in test-logic-reset from every state
    always_ff @(posedge testClk or negedge tckRst_n)
    begin
        if (!tckRst_n)
            state_q <= TAP_RESET;
        else
            state_q <= state_d;
    end

    assign tapState = state_q;

endmodule

// file: rtl/sbs_tap_top.sv
// boundary-scan test access port of a pipelined synchronous sram
// How it works
// - one bypass flip-flop sits between tdi and tdo, one stage of delay.
// - the bypass flip-flop is cleared when the bypass instruction takes effect.
// - boundary chain is 73 cells wide-configured, 54 cells narrow-configured.
// - boundary instructions load the io ring at capture-dr, shift it at shift-dr.
// - every scan register takes tdi at its msb and drives tdo from its lsb.
// - identification instruction loads the fixed 32-bit word at capture-dr.
// - identification instruction shifts that word out on tdo in shift-dr.
// - instruction register is three bits; five codes used, three reserved.
// - scan logic never drives the core or preloads outputs; it only captures.
// - instructions shift in during shift-ir and take effect only at update-ir.
// - all-zero instruction samples like sample, but floats the memory outputs.
// - identification instruction is loaded at power-up and in test-logic-reset.
// - float-sample routes the boundary chain and holds memory outputs floating.
// - sample snapshots all input and bidirectional balls at capture-dr, harmlessly.
// - update-dr under sample changes nothing, exactly like pause-dr.
// - bypass instruction in shift-dr routes the bypass flip-flop to tdo.
// - codes are 000 extest-lite, 001 id, 010 float, 100 sample, 111 bypass.
// - tms and tdi sampled on rising test clock; tdo changes on falling edge.
// - five rising edges with tms high reset the port, memory undisturbed.
// - capture-ir loads binary 01 into the two instruction lsbs.
`timescale 1ns/100ps
module sbs_tap_top #(
    parameter int BSR_LEN = sbs_pkg::BSR_LEN_X36
) (
    // system clock and power-up reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // test access port pins
    input wire logic testClk,
    input wire logic tmsPin,
    input wire logic tdiPin,
    output logic tdoOut,
    output logic tdoOe,
    // io ring seen by the capture cells, never driven back
    input wire logic [BSR_LEN-1:0] ioRing,
    // memory output driver float request, ref_clk domain
    output logic memOutFloat
);
    import sbs_pkg::*;

    // hardwired identification word
    localparam logic [ID_LEN-1:0] ID_WORD = {ID_REVISION, ID_DEPTH, ID_ARCH,
        (BSR_LEN == BSR_LEN_X18) ? ID_WIDTH_X18 : ID_WIDTH_X36, ID_VENDOR, ID_PRESENT};

    // data register selected by an instruction; reserved codes fall back to bypass
    function automatic sbs_dr_path_e drPath(input logic [IR_LEN-1:0] instr);
        sbs_dr_path_e path;
        path = PATH_BYPASS;
        case (instr)
            INSTR_IDCODE: path = PATH_ID;
            INSTR_EXTEST_LITE, INSTR_SAMPLE_FLOAT, INSTR_SAMPLE: path = PATH_BOUNDARY;
            default: path = PATH_BYPASS;
        endcase
        return path;
    endfunction

    function automatic logic floatsOutputs(input logic [IR_LEN-1:0] instr);
        return (instr == INSTR_EXTEST_LITE) || (instr == INSTR_SAMPLE_FLOAT);
    endfunction

    // reset release, one synchroniser per domain
    logic [1:0] refRstSync_q, refRstSync_d;
    logic [1:0] tckRstSync_q, tckRstSync_d;
    logic refRst_n;
    logic tckRst_n;

    always_comb
    begin
        refRstSync_d = {refRstSync_q[0], 1'b1};
        tckRstSync_d = {tckRstSync_q[0], 1'b1};
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            refRstSync_q <= 2'h0;
        else
            refRstSync_q <= refRstSync_d;
    end

    // the test clock may stand still, so its domain leaves reset only after two test edges
    always_ff @(posedge testClk or negedge rst_n)
    begin
        if (!rst_n)
            tckRstSync_q <= 2'h0;
        else
            tckRstSync_q <= tckRstSync_d;
    end

    assign refRst_n = refRstSync_q[1];
    assign tckRst_n = tckRstSync_q[1];

    // controller
    sbs_tap_state_e tapState;

    sbs_tap_fsm u_fsm (
        .testClk(testClk),
        .tckRst_n(tckRst_n),
        .tmsPin(tmsPin),
        .tapState(tapState)
    );

    // io ring synchroniser; the ring changes far faster than the test clock,
    // so a ball caught mid-transition still gives an arbitrary but settled bit
    logic [BSR_LEN-1:0] ioMeta_q, ioMeta_d;
    logic [BSR_LEN-1:0] ioSync_q, ioSync_d;

    always_comb
    begin
        ioMeta_d = ioRing;
        ioSync_d = ioMeta_q;
    end

    always_ff @(posedge testClk or negedge tckRst_n)
    begin
        if (!tckRst_n)
        begin
            ioMeta_q <= '0;
            ioSync_q <= '0;
        end
        else
        begin
            ioMeta_q <= ioMeta_d;
            ioSync_q <= ioSync_d;
        end
    end

    // instruction register: shift stage and active instruction
    logic [IR_LEN-1:0] irShift_q, irShift_d;
    logic [IR_LEN-1:0] irActive_q, irActive_d;
    logic floatReq_q, floatReq_d;

    always_comb
    begin
        irShift_d = irShift_q;
        irActive_d = irActive_q;
        case (tapState)
            TAP_RESET: irActive_d = INSTR_IDCODE;
            CAP_IR: irShift_d = IR_CAPTURE;
            SHIFT_IR: irShift_d = {tdiPin, irShift_q[IR_LEN-1:1]};
            UPD_IR: irActive_d = irShift_q;
            default: irActive_d = irActive_q;
        endcase
        floatReq_d = floatsOutputs(irActive_d);
    end

    always_ff @(posedge testClk or negedge tckRst_n)
    begin
        if (!tckRst_n)
        begin
            irShift_q <= IR_CAPTURE;
            irActive_q <= IR_RESET;
            floatReq_q <= 1'b0;
        end
        else
        begin
            irShift_q <= irShift_d;
            irActive_q <= irActive_d;
            floatReq_q <= floatReq_d;
        end
    end

    // data registers: bypass, identification, boundary chain
    sbs_dr_path_e path;
    logic bypass_q, bypass_d;
    logic [ID_LEN-1:0] idShift_q, idShift_d;
    logic [BSR_LEN-1:0] bsr_q, bsr_d;

    assign path = drPath(irActive_q);

    // capture only ever reads the ring; no preload or update stage exists
    always_comb
    begin
        bypass_d = bypass_q;
        idShift_d = idShift_q;
        bsr_d = bsr_q;
        case (tapState)
            CAP_DR:
                case (path)
                    PATH_ID: idShift_d = ID_WORD;
                    PATH_BOUNDARY: bsr_d = ioSync_q;
                    default: bypass_d = 1'b0;
                endcase
            SHIFT_DR:
                case (path)
                    PATH_ID: idShift_d = {tdiPin, idShift_q[ID_LEN-1:1]};
                    PATH_BOUNDARY: bsr_d = {tdiPin, bsr_q[BSR_LEN-1:1]};
                    default: bypass_d = tdiPin;
                endcase
            UPD_IR:
                if (irShift_q == INSTR_BYPASS)
                    bypass_d = 1'b0;
            default: bypass_d = bypass_q;  // update-dr holds like pause-dr
        endcase
    end

    always_ff @(posedge testClk or negedge tckRst_n)
    begin
        if (!tckRst_n)
        begin
            bypass_q <= BYPASS_RESET;
            idShift_q <= '0;
            bsr_q <= '0;
        end
        else
        begin
            bypass_q <= bypass_d;
            idShift_q <= idShift_d;
            bsr_q <= bsr_d;
        end
    end

    // tdo launched on the falling edge, half a cycle of margin at the next device
    logic tdoData_q, tdoData_d;
    logic tdoOe_q, tdoOe_d;

    always_comb
    begin
        tdoData_d = tdoData_q;
        case (tapState)
            SHIFT_IR: tdoData_d = irShift_q[0];
            SHIFT_DR:
                case (path)
                    PATH_ID: tdoData_d = idShift_q[0];
                    PATH_BOUNDARY: tdoData_d = bsr_q[0];
                    default: tdoData_d = bypass_q;
                endcase
            default: tdoData_d = tdoData_q;
        endcase
        tdoOe_d = (tapState == SHIFT_IR) || (tapState == SHIFT_DR);
    end

    always_ff @(negedge testClk or negedge tckRst_n)
    begin
        if (!tckRst_n)
        begin
            tdoData_q <= 1'b0;
            tdoOe_q <= 1'b0;
        end
        else
        begin
            tdoData_q <= tdoData_d;
            tdoOe_q <= tdoOe_d;
        end
    end

    assign tdoOut = tdoData_q;
    assign tdoOe = tdoOe_q;

    // float request crosses into the memory clock domain as a level
    logic floatMeta_q, floatMeta_d;
    logic floatSync_q, floatSync_d;

    always_comb
    begin
        floatMeta_d = floatReq_q;
        floatSync_d = floatMeta_q;
    end

    always_ff @(posedge ref_clk or negedge refRst_n)
    begin
        if (!refRst_n)
        begin
            floatMeta_q <= 1'b0;
            floatSync_q <= 1'b0;
        end
        else
        begin
            floatMeta_q <= floatMeta_d;
            floatSync_q <= floatSync_d;
        end
    end

    assign memOutFloat = floatSync_q;

    // checks
    property p_bypass_stage;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == SHIFT_DR && path == PATH_BYPASS) ##1 (tapState == SHIFT_DR) |->
            (tdoOut == $past(tdiPin));
    endproperty
    a_bypass_stage: assert property (p_bypass_stage) else $error("bypass is not one stage");

    property p_bypass_clear;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == UPD_IR && irShift_q == INSTR_BYPASS) |=> (bypass_q == 1'b0);
    endproperty
    a_bypass_clear: assert property (p_bypass_clear) else $error("bypass not cleared");

    property p_boundary_shift;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == SHIFT_DR && path == PATH_BOUNDARY) |=>
            (bsr_q[BSR_LEN-1] == $past(tdiPin)) && (bsr_q[BSR_LEN-2:0] == $past(bsr_q[BSR_LEN-1:1]));
    endproperty
    a_boundary_shift: assert property (p_boundary_shift) else $error("boundary shift wrong");

    property p_id_capture;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == CAP_DR && irActive_q == INSTR_IDCODE) |=> (idShift_q == ID_WORD);
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id word not captured");

    property p_ir_capture;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == CAP_IR) |=> (irShift_q[1:0] == 2'h1);
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("ir capture pattern wrong");

    property p_ir_reset;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == TAP_RESET) |=> (irActive_q == INSTR_IDCODE);
    endproperty
    a_ir_reset: assert property (p_ir_reset) else $error("ir not idcode after reset");

    property p_ir_update_only;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState != UPD_IR && tapState != TAP_RESET) |=> $stable(irActive_q);
    endproperty
    a_ir_update_only: assert property (p_ir_update_only) else $error("ir changed outside update");

    property p_tms_reset;
        @(posedge testClk) disable iff (!tckRst_n)
        (tmsPin [*5]) |=> (tapState == TAP_RESET);
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("five tms highs did not reset");

    property p_tdo_enable;
        @(posedge testClk) disable iff (!tckRst_n)
        ##1 (tdoOe == ((tapState == SHIFT_IR) || (tapState == SHIFT_DR)));
    endproperty
    a_tdo_enable: assert property (p_tdo_enable) else $error("tdo enable outside shift");

    property p_update_dr_hold;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == UPD_DR && path == PATH_BOUNDARY) |=> $stable(bsr_q);
    endproperty
    a_update_dr_hold: assert property (p_update_dr_hold) else $error("update-dr changed chain");

    property p_float_follow;
        @(posedge ref_clk) disable iff (!refRst_n)
        (floatReq_q [*3]) |-> memOutFloat;
    endproperty
    a_float_follow: assert property (p_float_follow) else $error("outputs not floated");

    property p_float_decode;
        @(posedge testClk) disable iff (!tckRst_n)
        (tapState == UPD_IR && irShift_q == INSTR_EXTEST_LITE) |=> floatReq_q;
    endproperty
    a_float_decode: assert property (p_float_decode) else $error("all-zero code not floating");

    c_bypass_shift: cover property (@(posedge testClk) disable iff (!tckRst_n)
        (tapState == SHIFT_DR && path == PATH_BYPASS));
    c_id_capture: cover property (@(posedge testClk) disable iff (!tckRst_n)
        (tapState == CAP_DR && path == PATH_ID));
    c_boundary_shift: cover property (@(posedge testClk) disable iff (!tckRst_n)
        (tapState == SHIFT_DR && path == PATH_BOUNDARY));
    c_float: cover property (@(posedge ref_clk) disable iff (!refRst_n) memOutFloat);

endmodule

// file: dv/sbs_jtag_ctl.sv
// behavioural board-level test controller for the scan port
`timescale 1ns/100ps
module sbs_jtag_ctl (
    // test access port pins driven by the controller
    output logic testClk,
    output logic tmsPin,
    output logic tdiPin,
    // test data returned by the device
    input wire logic tdoOut,
    input wire logic tdoOe
);
    // 160 ns period keeps the test clock under 10 MHz
    localparam int HALF = 80;

    // cleared when tdo enable disagrees with the expected state
    logic oeOk;

    // clock stands still low between frames; tms and tdi rest at their pull-up level
    initial
    begin
        testClk = 1'b0;
        tmsPin = 1'b1;
        tdiPin = 1'b1;
        oeOk = 1'b1;
    end

    // one test clock: pins change after the falling edge, tdo read just before the rise
    task automatic tick(input logic tms, input logic tdi, input logic expOe, output logic tdo);
        tmsPin <= tms;
        tdiPin <= tdi;
        // edges sit 1.5 ns off the memory clock grid, so the float crossing sees unaligned clocks
        #(HALF - 2.5);
        tdo = tdoOut;
        if (expOe !== 1'bx && tdoOe !== expOe)
        begin
            oeOk = 1'b0;
        end
        #1;
        testClk = 1'b1;
        #(HALF);
        testClk = 1'b0;
        #1.5;
    endtask

    // five rising edges with tms high, then park in idle
    task automatic tmsReset;
        logic d;
        repeat (5) tick(1'b1, 1'b1, 1'bx, d);
        tick(1'b0, 1'b1, 1'bx, d);
    endtask

    // full ir or dr scan from idle back to idle, lsb first
    // the bench never loads a reserved code
    task automatic scan(input logic isIr, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic d;
        dout = '0;
        oeOk = 1'b1;
        tick(1'b1, 1'b1, 1'b0, d);
        if (isIr)
        begin
            tick(1'b1, 1'b1, 1'b0, d);
        end
        tick(1'b0, 1'b1, 1'b0, d);
        tick(1'b0, 1'b1, 1'b0, d);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], 1'b1, dout[i]);
        end
        tick(1'b1, 1'b1, 1'b0, d);
        tick(1'b0, 1'b1, 1'b0, d);
    endtask
endmodule

// file: dv/sbs_tap_top_tb.sv
// self-checking bench for the sram boundary-scan port
`timescale 1ns/100ps
module sbs_tap_top_tb;
    import sbs_pkg::*;

    localparam int BSR = BSR_LEN_X36;
    localparam logic [31:0] ID_EXP = {ID_REVISION, ID_DEPTH, ID_ARCH, ID_WIDTH_X36, ID_VENDOR, ID_PRESENT};
    localparam logic [BSR-1:0] RING_PAT = 73'h15a_3c96_e10f_7d2b_48c3;

    logic ref_clk;
    logic rst_n;
    logic testClk;
    logic tmsPin;
    logic tdiPin;
    logic tdoOut;
    logic tdoOe;
    logic [BSR-1:0] ioRing;
    logic memOutFloat;
    int mismatches = 0;
    int checkCount = 0;

    sbs_jtag_ctl ctl (
        .testClk(testClk),
        .tmsPin(tmsPin),
        .tdiPin(tdiPin),
        .tdoOut(tdoOut),
        .tdoOe(tdoOe)
    );

    sbs_tap_top #(.BSR_LEN(BSR)) uut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .testClk(testClk),
        .tmsPin(tmsPin),
        .tdiPin(tdiPin),
        .tdoOut(tdoOut),
        .tdoOe(tdoOe),
        .ioRing(ioRing),
        .memOutFloat(memOutFloat)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        checkCount++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic stopTest;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic readId(input string what);
        logic [127:0] d;
        ctl.scan(1'b0, ID_LEN, '0, d);
        check(d[31:0], ID_EXP, what);
    endtask

    task automatic testPowerUp;
        check(memOutFloat, 1'b0, "float after power-up");
        readId("id after power-up");
    endtask

    // every used code once, reserved codes skipped: ir capture, float decode and the selected path
    task automatic testAllCodes;
        logic [127:0] d;
        logic [2:0] code;
        logic expFloat;
        for (int c = 0; c < 8; c++)
        begin
            code = 3'(c);
            if (c == 3 || c == 5 || c == 6)
            begin
                continue;
            end
            // ring held still, so every cell including the clock cell is compared
            @(posedge ref_clk) ioRing <= c[1] ? RING_PAT : ~RING_PAT;
            ctl.scan(1'b1, IR_LEN, 128'(code), d);
            check(d[2:0], IR_CAPTURE, "captured instruction");
            check(ctl.oeOk, 1'b1, "tdo enable in ir scan");
            expFloat = (code == INSTR_EXTEST_LITE) || (code == INSTR_SAMPLE_FLOAT);
            check(memOutFloat, expFloat, "output float");
            if (code == INSTR_IDCODE)
            begin
                readId("id path");
            end
            else if (code inside {INSTR_EXTEST_LITE, INSTR_SAMPLE_FLOAT, INSTR_SAMPLE})
            begin
                ctl.scan(1'b0, BSR, '0, d);
                check(d[BSR-1:0], ioRing, "boundary capture");
                check(memOutFloat, expFloat, "float after update-dr");
            end
            else
            begin
                ctl.scan(1'b0, 8, 128'h00b4, d);
                check(d[7:0], 8'h68, "bypass stream");
            end
            check(ctl.oeOk, 1'b1, "tdo enable in dr scan");
        end
    endtask

    // five tms-high edges abort a shift in progress and restore the id instruction
    task automatic testTmsReset;
        logic [127:0] d;
        logic b;
        ctl.scan(1'b1, IR_LEN, 128'(INSTR_EXTEST_LITE), d);
        check(memOutFloat, 1'b1, "float before tms reset");
        ctl.tick(1'b1, 1'b1, 1'bx, b);
        ctl.tick(1'b0, 1'b1, 1'bx, b);
        repeat (3) ctl.tick(1'b0, 1'b0, 1'bx, b);
        ctl.tmsReset();
        check(memOutFloat, 1'b0, "float after tms reset");
        readId("id after tms reset");
    endtask

    // power-up reset in mid-run clears the float request and reloads the id instruction
    task automatic testAsyncReset;
        logic [127:0] d;
        ctl.scan(1'b1, IR_LEN, 128'(INSTR_SAMPLE_FLOAT), d);
        check(memOutFloat, 1'b1, "float before reset");
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check(memOutFloat, 1'b0, "float after reset");
        ctl.tmsReset();
        readId("id after reset");
    endtask

    initial
    begin
        #500000;
        mismatches++;
        $display("MISMATCH at %0t: run did not finish", $time);
        stopTest();
    end

    initial
    begin
        rst_n = 1'b0;
        ioRing = RING_PAT;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        ctl.tmsReset();
        testPowerUp();
        testAllCodes();
        testTmsReset();
        testAsyncReset();
        stopTest();
    end
endmodule
